// file: inc/pcsfa_pkg.sv
// Constants and types shared by the program counter, stack and flash data access logic.
//
// Contract
// (R1) Counter holds next address and adds one each cycle unless loaded.
// (R2) Jump loads counter bits 8..0 from the instruction; low byte is pc_low_byte.
// (R3) Jump or call takes counter bit 9 from status bit 5, the page bit.
// (R4) Call or pc_low_byte write loads bits 7..0 and forces counter bit 8 to zero.
// (R5) Reset sets all counter bits; the next instruction wraps it to zero.
// (R6) Reset clears the page bit so jumps go to page 0.
// (R7) Two-level, twelve-bit return stack with no overflow or underflow flag.
// (R8) Call moves level one to level two, then stores counter plus one.
// (R9) Return moves level one to counter, level two to level one, loads literal.
// (R10) The indirect data port reaches the register addressed by the pointer.
// (R11) Pointer zero: indirect read gives zero, indirect write changes nothing.
// (R12) Pointer bits 4..0 select location 00h to 1Fh in the bank.
// (R13) Pointer bits 6..5 select bank 0 to 3; bit 7 reads as one.
// (R14) Flash block is 64 bytes in 8 rows at address plus 400h, low byte only.
// (R15) Flash address has six bits 5..0; flash data byte has eight bits.
// (R16) Execution stalls while a flash read or write cycle runs.
// (R17) Row erase enable turns a write into a row erase; cleared when erase ends.
// (R18) Write error flag is set when reset cuts a write short, else zero.
// (R19) Write or erase may start only while write enable is one.
// (R20) Write start reads one until the cycle finishes, then returns to zero.
// (R21) Read start requests a flash read into the flash data byte.
// (R22) Read data is in the flash data byte by the next instruction cycle.
// (R23) Row erase enable clears unless write enable is set the next cycle.
// (R24) Write enable clears unless write start is set the next cycle.
// (R25) Flash control bits reset to zero; read start clears after the load.
package pcsfa_pkg;

   // ***********************************************************************
   // Widths, reset values and addresses.
   // ***********************************************************************
   localparam int             PC_W            = 11;
   localparam int             STACK_W         = 12;
   localparam int             STACK_DEPTH     = 2;
   localparam int             FLASH_ADDR_W    = 6;
   localparam int             CLKS_PER_INSTR  = 4;
   localparam logic [10:0]    PC_RESET        = 11'h7ff;
   localparam logic [10:0]    FLASH_BASE      = 11'h400;
   localparam logic [6:0]     PTR_RESET       = 7'h00;
   localparam logic [7:0]     FDATA_RESET     = 8'h00;
   localparam logic [5:0]     FADDR_RESET     = 6'h00;
   localparam logic [4:0]     ADDR_IND_PORT   = 5'h00;
   localparam logic [4:0]     ADDR_PC_LOW     = 5'h02;
   localparam logic [4:0]     ADDR_STATUS     = 5'h03;
   localparam logic [4:0]     ADDR_PTR        = 5'h04;
   localparam logic [5:0]     ADDR_FCON       = 6'h21;
   localparam logic [5:0]     ADDR_FDATA      = 6'h25;
   localparam logic [5:0]     ADDR_FADDR      = 6'h26;

   // ***********************************************************************
   // Field positions.
   // ***********************************************************************
   localparam int             STATUS_PAGE     = 5;
   localparam int             PTR_BANK_LSB    = 5;
   localparam int             CON_FREE        = 4;
   localparam int             CON_WERR        = 3;
   localparam int             CON_WEN         = 2;
   localparam int             CON_WR          = 1;
   localparam int             CON_RD          = 0;

   typedef enum logic [1:0] {
      FL_IDLE  = 2'b00,
      FL_READ  = 2'b01,
      FL_WRITE = 2'b10,
      FL_ERASE = 2'b11
   } pcsfa_flash_state_type;

endpackage : pcsfa_pkg

// file: rtl/pcsfa_core.sv
// Program counter, return stack, indirect addressing and flash data access path.
`timescale 1ns/1ps
module pcsfa_core
   import pcsfa_pkg::*;
#(
   parameter int CLKS_PER_CYCLE = CLKS_PER_INSTR
)(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        op_jump,
   input  wire logic        op_call,
   input  wire logic        op_return,
   input  wire logic [8:0]  op_literal,
   input  wire logic        file_rd,
   input  wire logic        file_wr,
   input  wire logic        file_bsf,
   input  wire logic [4:0]  file_addr,
   input  wire logic [7:0]  file_wdata,
   input  wire logic [7:0]  flash_rdata,
   input  wire logic        flash_done,
   input  wire logic        flash_cut_short,
   output logic      [10:0] program_counter,
   output logic             instr_cycle,
   output logic             stall,
   output logic             w_load,
   output logic      [7:0]  w_data,
   output logic      [7:0]  file_rdata,
   output logic             file_rhit,
   output logic      [6:0]  mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic      [7:0]  mem_wdata,
   output logic             page_preselect_bit,
   output logic      [10:0] flash_addr,
   output logic      [7:0]  flash_wdata,
   output logic             flash_rd,
   output logic             flash_wr,
   output logic             flash_erase
);

   // ***********************************************************************
   // Instruction cycle enable.
   // ***********************************************************************
   localparam int CNT_W = (CLKS_PER_CYCLE > 1) ? $clog2(CLKS_PER_CYCLE) : 1;

   logic [CNT_W-1:0]      div_cnt;
   pcsfa_flash_state_type state;
   pcsfa_flash_state_type next_state;
   logic [6:0]            ptr;
   logic [7:0]            fdata;
   logic [5:0]            faddr;
   logic                  free;
   logic                  werr;
   logic                  wen;
   logic                  wr;
   logic                  rd;
   logic                  free_armed;
   logic                  wen_armed;
   logic                  caught;
   logic [STACK_W-1:0]    stack_l1;
   logic [STACK_W-1:0]    stack_l2;

   wire cyc_en  = (div_cnt == CNT_W'(CLKS_PER_CYCLE - 1));
   wire busy    = (state != FL_IDLE);
   wire exec_go = cyc_en & ~busy; // see (R16)

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= cyc_en ? '0 : div_cnt + 1'b1;
      end
   end

   // ***********************************************************************
   // Address decode for direct and indirect file access.
   // ***********************************************************************
   wire       indirect   = (file_addr == ADDR_IND_PORT);
   wire [6:0] eff_addr   = indirect ? ptr : {ptr[6:PTR_BANK_LSB], file_addr}; // see (R10) (R12) (R13)
   wire       ind_null   = indirect & (ptr == 7'h00); // see (R11)
   wire       hit_pc_low = ~ind_null & (eff_addr[4:0] == ADDR_PC_LOW);
   wire       hit_status = ~ind_null & (eff_addr[4:0] == ADDR_STATUS);
   wire       hit_ptr    = ~ind_null & (eff_addr[4:0] == ADDR_PTR);
   wire       hit_fcon   = ~ind_null & (eff_addr[5:0] == ADDR_FCON);
   wire       hit_fdata  = ~ind_null & (eff_addr[5:0] == ADDR_FDATA);
   wire       hit_faddr  = ~ind_null & (eff_addr[5:0] == ADDR_FADDR);
   wire       own_hit    = ind_null | hit_pc_low | hit_status | hit_ptr | hit_fcon | hit_fdata | hit_faddr;
   wire       wr_go      = exec_go & file_wr & ~ind_null; // see (R11)
   wire       wr_pc_low  = wr_go & hit_pc_low;
   wire       wr_fcon    = wr_go & hit_fcon;

   wire [7:0] status_byte = 8'(page_preselect_bit) << STATUS_PAGE;
   wire [7:0] fcon_byte   = {3'b000, free, werr, wen, wr, rd};
   wire [7:0] own_rdata   = ind_null   ? 8'h00 :
                            hit_pc_low ? program_counter[7:0] :
                            hit_status ? status_byte :
                            hit_ptr    ? {1'b1, ptr} : // see (R13)
                            hit_fcon   ? fcon_byte :
                            hit_fdata  ? fdata :
                            hit_faddr  ? {2'b00, faddr} : 8'h00;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         file_rdata <= 8'h00;
         file_rhit  <= 1'b0;
      end else begin
         file_rhit <= exec_go & file_rd & own_hit;
         if (exec_go & file_rd) begin
            file_rdata <= own_rdata;
         end
      end
   end

   // Accesses that this block does not answer go out to the data memory.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mem_addr  <= 7'h00;
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         mem_rd <= exec_go & file_rd & ~own_hit; // see (R10)
         mem_wr <= exec_go & file_wr & ~own_hit;
         if (exec_go) begin
            mem_addr  <= eff_addr;
            mem_wdata <= file_wdata;
         end
      end
   end

   // ***********************************************************************
   // Program counter and return stack.
   // ***********************************************************************
   wire [10:0] pc_inc    = program_counter + 11'h001; // see (R5)
   wire        pg        = page_preselect_bit;
   wire [10:0] next_pc   = !exec_go  ? program_counter :
                           op_return ? stack_l1[PC_W-1:0] : // see (R9)
                           op_jump   ? {1'b0, pg, op_literal} : // see (R2) (R3)
                           op_call   ? {1'b0, pg, 1'b0, op_literal[7:0]} : // see (R4)
                           wr_pc_low ? {1'b0, pg, 1'b0, file_wdata} : pc_inc; // see (R1)
   wire [STACK_W-1:0] push_word = {{(STACK_W - PC_W){1'b0}}, pc_inc};

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         program_counter <= PC_RESET; // see (R5)
         instr_cycle     <= 1'b0;
      end else begin
         program_counter <= next_pc;
         instr_cycle     <= exec_go;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         w_load <= 1'b0;
         w_data <= 8'h00;
      end else begin
         w_load <= exec_go & op_return; // see (R9)
         if (exec_go & op_return) begin
            w_data <= op_literal[7:0];
         end
      end
   end

   // The stack has no overflow or underflow flag.
   pcsfa_stack #(
      .WIDTH (STACK_W),
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .push      (exec_go & op_call),
      .pop       (exec_go & op_return),
      .push_data (push_word),
      .level1    (stack_l1),
      .level2    (stack_l2)
   ); // see (R7) (R8)

   // ***********************************************************************
   // Status page bit, pointer and flash data registers.
   // ***********************************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         page_preselect_bit <= 1'b0; // see (R6)
         ptr                <= PTR_RESET;
         faddr              <= FADDR_RESET;
      end else begin
         if (wr_go & hit_status) begin
            page_preselect_bit <= file_wdata[STATUS_PAGE];
         end
         if (wr_go & hit_ptr) begin
            ptr <= file_wdata[6:0];
         end
         if (wr_go & hit_faddr) begin
            faddr <= file_wdata[FLASH_ADDR_W-1:0]; // see (R15)
         end
      end
   end

   wire done_rd    = (state == FL_READ) & flash_done;
   wire done_erase = (state == FL_ERASE) & flash_done;
   wire done_wr    = ((state == FL_WRITE) | done_erase) & flash_done;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fdata <= FDATA_RESET;
      end else if (done_rd) begin
         fdata <= flash_rdata; // see (R22)
      end else if (wr_go & hit_fdata) begin
         fdata <= file_wdata;
      end
   end

   // ***********************************************************************
   // Flash control bits and the unlock sequence.
   // ***********************************************************************
   wire set_free    = wr_fcon & file_wdata[CON_FREE] & ~free;
   wire set_wen     = wr_fcon & file_bsf & file_wdata[CON_WEN] & ~wen;
   wire set_wr      = wr_fcon & file_bsf & file_wdata[CON_WR] & ~wr & wen; // see (R19) (R20)
   wire set_rd      = wr_fcon & file_bsf & file_wdata[CON_RD] & ~rd; // see (R21)
   wire expire_free = exec_go & free_armed & ~set_wen; // see (R23)
   wire expire_wen  = exec_go & wen_armed & ~set_wr; // see (R24)
   wire cut_catch   = ~caught & flash_cut_short; // see (R18)

   wire next_free = done_erase  ? 1'b0 : // see (R17)
                    expire_free ? 1'b0 :
                    wr_fcon     ? file_wdata[CON_FREE] : free;
   wire next_wen  = expire_wen  ? 1'b0 :
                    wr_fcon     ? file_wdata[CON_WEN] & (wen | file_bsf) : wen;
   wire next_wr   = done_wr ? 1'b0 : set_wr | wr; // see (R20)
   wire next_rd   = done_rd ? 1'b0 : set_rd | rd; // see (R25)
   wire next_werr = cut_catch ? 1'b1 :
                    done_wr   ? 1'b0 :
                    wr_fcon   ? file_wdata[CON_WERR] : werr;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         free <= 1'b0; // see (R25)
         wen  <= 1'b0;
         wr   <= 1'b0;
         rd   <= 1'b0;
         werr <= 1'b0;
      end else begin
         free <= next_free;
         wen  <= next_wen;
         wr   <= next_wr;
         rd   <= next_rd;
         werr <= next_werr;
      end
   end

   // Arm flags remember a bit set in the last executed instruction cycle.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         free_armed <= 1'b0;
         wen_armed  <= 1'b0;
         caught     <= 1'b0;
      end else begin
         caught <= 1'b1;
         if (exec_go) begin
            free_armed <= set_free;
            wen_armed  <= set_wen;
         end
      end
   end

   // ***********************************************************************
   // Flash cycle sequencer.
   // ***********************************************************************
   always_comb begin
      next_state = state;
      case (state)
         FL_IDLE: begin
            if (set_wr) begin
               next_state = free ? FL_ERASE : FL_WRITE; // see (R17)
            end else if (set_rd) begin
               next_state = FL_READ;
            end
         end
         FL_READ, FL_WRITE, FL_ERASE: begin
            if (flash_done) begin
               next_state = FL_IDLE;
            end
         end
         default: begin
            next_state = FL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state       <= FL_IDLE;
         stall       <= 1'b0;
         flash_rd    <= 1'b0;
         flash_wr    <= 1'b0;
         flash_erase <= 1'b0;
      end else begin
         state       <= next_state;
         stall       <= (next_state != FL_IDLE); // see (R16)
         flash_rd    <= (next_state == FL_READ);
         flash_wr    <= (next_state == FL_WRITE);
         flash_erase <= (next_state == FL_ERASE);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flash_addr  <= FLASH_BASE;
         flash_wdata <= 8'h00;
      end else if (set_wr | set_rd) begin
         flash_addr  <= FLASH_BASE + 11'(faddr); // see (R14)
         flash_wdata <= fdata;
      end
   end

   // ***********************************************************************
   // Assertions.
   // ***********************************************************************
   wire plain_step = exec_go & ~op_jump & ~op_call & ~op_return & ~wr_pc_low;

   sequence s_wr_start;
      exec_go && set_wr;
   endsequence

   sequence s_wr_busy;
      wr && stall && (flash_wr || flash_erase);
   endsequence

   property p_pc_step;
      @(posedge clk_sys) disable iff (sys_rst) plain_step |=> program_counter == $past(pc_inc);
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("counter did not advance by one"); // see (R1)

   property p_jump_load;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && op_jump |=>
         program_counter[8:0] == $past(op_literal) && program_counter[9] == $past(page_preselect_bit);
   endproperty
   a_jump_load: assert property (p_jump_load) else $error("jump target wrong"); // see (R2) (R3)

   property p_call_bit8;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && !op_return && !op_jump && (op_call || wr_pc_low) |=>
         !program_counter[8] && program_counter[9] == $past(page_preselect_bit);
   endproperty
   a_call_bit8: assert property (p_call_bit8) else $error("bit 8 not cleared on call"); // see (R4)

   property p_wrap;
      @(posedge clk_sys) disable iff (sys_rst) plain_step && program_counter == PC_RESET |=> program_counter == 11'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero"); // see (R5)

   property p_call_push;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && op_call && !op_return |=>
         stack_l1 == $past(push_word) && stack_l2 == $past(stack_l1);
   endproperty
   a_call_push: assert property (p_call_push) else $error("stack push wrong"); // see (R8)

   property p_return;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && op_return |=> program_counter == $past(stack_l1[PC_W-1:0])
         && stack_l1 == $past(stack_l2) && w_load && w_data == $past(op_literal[7:0]);
   endproperty
   a_return: assert property (p_return) else $error("return did not pop"); // see (R9)

   property p_null_read;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && (file_rd || file_wr) && ind_null |=>
         !mem_rd && !mem_wr && (!file_rhit || file_rdata == 8'h00);
   endproperty
   a_null_read: assert property (p_null_read) else $error("null indirect access leaked"); // see (R11)

   property p_wr_holds;
      @(posedge clk_sys) disable iff (sys_rst) s_wr_start |=> s_wr_busy;
   endproperty
   a_wr_holds: assert property (p_wr_holds) else $error("write start not held"); // see (R20) (R16)

   property p_inhibit;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && wr_fcon && file_bsf && file_wdata[CON_WR] && !wen |=>
         !wr && state == FL_IDLE;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("write started without enable"); // see (R19)

   property p_wen_expire;
      @(posedge clk_sys) disable iff (sys_rst) expire_wen |=> !wen;
   endproperty
   a_wen_expire: assert property (p_wen_expire) else $error("write enable not dropped"); // see (R24)

   property p_free_expire;
      @(posedge clk_sys) disable iff (sys_rst) exec_go && free_armed && !set_wen |=> !free;
   endproperty
   a_free_expire: assert property (p_free_expire) else $error("erase enable not dropped"); // see (R23)

   property p_read_done;
      @(posedge clk_sys) disable iff (sys_rst) done_rd |=> fdata == $past(flash_rdata) && !rd && !stall;
   endproperty
   a_read_done: assert property (p_read_done) else $error("read data not loaded"); // see (R22) (R25)

   property p_erase_done;
      @(posedge clk_sys) disable iff (sys_rst) done_erase && !cut_catch |=> !free && !wr && !werr;
   endproperty
   a_erase_done: assert property (p_erase_done) else $error("erase end not cleared"); // see (R17) (R18)

endmodule : pcsfa_core

// file: rtl/pcsfa_stack.sv
// Return address stack with a parameterised number of levels.
`timescale 1ns/1ps
module pcsfa_stack
   import pcsfa_pkg::*;
#(
   parameter int WIDTH = STACK_W,
   parameter int DEPTH = STACK_DEPTH
)(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] level1,
   output logic      [WIDTH-1:0] level2
);

   logic [WIDTH-1:0] level [DEPTH];

   // Push shifts every level down; pop shifts up and the last level keeps its value.
   for (genvar i = 0; i < DEPTH; i++) begin : g_level
      wire [WIDTH-1:0] below = (i == 0) ? push_data : level[(i == 0) ? 0 : i - 1];
      wire [WIDTH-1:0] above = (i == DEPTH - 1) ? level[i] : level[(i == DEPTH - 1) ? i : i + 1];
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            level[i] <= '0;
         end else if (push) begin
            level[i] <= below; // see (R8)
         end else if (pop) begin
            level[i] <= above; // see (R9)
         end
      end
   end

   assign level1 = level[0];
   assign level2 = level[1];

endmodule : pcsfa_stack

// file: sim/pcsfa_flash_model.sv
// Behavioural flash data block that serves the core's read, write and erase requests.
`timescale 1ns/1ps
module pcsfa_flash_model #(
   parameter int LAT = 4
)(
   input  wire logic        clk_sys,
   input  wire logic [10:0] flash_addr,
   input  wire logic [7:0]  flash_wdata,
   input  wire logic        flash_rd,
   input  wire logic        flash_wr,
   input  wire logic        flash_erase,
   output logic      [7:0]  flash_rdata,
   output logic             flash_done
);
   logic [7:0] mem [64];
   int         cnt = 0;
   initial begin
      flash_done = 1'b0;
      flash_rdata = 8'h00;
   end
   // Read data is only meaningful with done; otherwise it toggles every cycle.
   always @(posedge clk_sys) begin
      flash_done <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if ((flash_rd || flash_wr || flash_erase) && !flash_done) begin
         cnt <= cnt + 1;
         if (cnt == LAT) begin
            cnt <= 0;
            flash_done <= 1'b1;
            if (flash_rd) flash_rdata <= mem[flash_addr[5:0]];
            if (flash_wr) mem[flash_addr[5:0]] <= flash_wdata;
            if (flash_erase) for (int i = 0; i < 8; i++) mem[{flash_addr[5:3], i[2:0]}] <= 8'hff;
         end
      end
   end
endmodule : pcsfa_flash_model

// file: sim/test_pcsfa_core.sv
// Self-checking bench for the counter, stack, indirect and flash data paths.
`timescale 1ns/1ps
module test_pcsfa_core;
   import pcsfa_pkg::*;
   localparam logic [5:0] NOP = 6'h00, JMP = 6'h20, CAL = 6'h10, RET = 6'h08;
   localparam logic [5:0] RDF = 6'h04, WRF = 6'h02, SETB = 6'h03;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        op_jump, op_call, op_return, file_rd, file_wr, file_bsf;
   logic [8:0]  op_literal;
   logic [4:0]  file_addr;
   logic [7:0]  file_wdata, flash_rdata, w_data, file_rdata, mem_wdata, flash_wdata, rdv;
   logic        flash_done, instr_cycle, stall, w_load, file_rhit, mem_rd, mem_wr;
   logic        page_preselect_bit, flash_rd, flash_wr, flash_erase;
   logic [10:0] program_counter, flash_addr;
   logic [6:0]  mem_addr;
   logic [3:0]  pul;
   logic        flash_cut_short = 1'b0;
   int          fails = 0;
   int          samples_checked = 0;
   pcsfa_core pcsfa_core_i (.*);
   pcsfa_flash_model pcsfa_flash_model_i (.*);
   always #4 clk_sys = ~clk_sys;
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Holds one instruction until it executes, keeping the one-clock pulses it caused.
   task automatic ex(input logic [5:0] op, input logic [8:0] lit, input logic [4:0] a, input logic [7:0] d);
      int n;
      {op_jump, op_call, op_return, file_rd, file_wr, file_bsf} = op;
      op_literal = lit;
      file_addr = a;
      file_wdata = d;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (instr_cycle !== 1'b1 && n < 200);
      if (n >= 200) begin
         fails++;
         print_verdict();
      end
      pul = {w_load, file_rhit, mem_rd, mem_wr};
      rdv = file_rdata;
      {op_jump, op_call, op_return, file_rd, file_wr, file_bsf} = NOP;
      @(negedge clk_sys);
   endtask : ex
   task automatic pcx(input logic [5:0] op, input logic [8:0] lit, input logic [4:0] a, input logic [7:0] d,
                      input logic [10:0] e);
      ex(op, lit, a, d);
      chk(program_counter, e);
   endtask : pcx
   task automatic t_reset();
      chk(program_counter, 11'h7ff);
      chk(page_preselect_bit, 1'b0);
      chk(flash_addr, 11'h400);
      pcx(NOP, '0, '0, '0, 11'h000);
      pcx(NOP, '0, '0, '0, 11'h001);
   endtask : t_reset
   task automatic t_branch();
      pcx(WRF, '0, 5'h03, 8'h20, 11'h002);
      chk(page_preselect_bit, 1'b1);
      pcx(JMP, 9'h1a5, '0, '0, 11'h3a5);
      pcx(CAL, 9'h1f0, '0, '0, 11'h2f0);
      pcx(CAL, 9'h011, '0, '0, 11'h211);
      pcx(CAL, 9'h022, '0, '0, 11'h222);
      pcx(RET, 9'h05a, '0, '0, 11'h212);
      chk({pul[3], w_data}, 9'h15a);
      pcx(RET, '0, '0, '0, 11'h2f1);
      pcx(RET, '0, '0, '0, 11'h2f1);
      pcx(WRF, '0, 5'h02, 8'h33, 11'h233);
      pcx(WRF, '0, 5'h03, 8'h00, 11'h234);
   endtask : t_branch
   task automatic t_indirect();
      ex(WRF, '0, 5'h04, 8'h4c);
      ex(RDF, '0, 5'h04, '0);
      chk({pul[2], rdv}, 9'h1cc);
      ex(RDF, '0, 5'h00, '0);
      chk({pul[1], mem_addr}, 8'hcc);
      ex(WRF, '0, 5'h00, 8'h5c);
      chk({pul[0], mem_addr, mem_wdata}, 16'hcc5c);
      ex(WRF, '0, 5'h04, 8'h00);
      ex(RDF, '0, 5'h00, '0);
      chk({pul[2:1], rdv}, 10'h200);
      ex(WRF, '0, 5'h00, 8'h77);
      chk(pul[0], 1'b0);
   endtask : t_indirect
   // Resets in mid-run while the array reports a cut write, then reads the error flag.
   task automatic t_cut();
      flash_cut_short = 1'b1;
      sys_rst = 1'b1;
      @(negedge clk_sys);
      sys_rst = 1'b0;
      chk(program_counter, 11'h7ff);
      @(negedge clk_sys);
      flash_cut_short = 1'b0;
      ex(WRF, '0, 5'h04, 8'h20);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv[3], 1'b1);
   endtask : t_cut
   task automatic t_flash();
      ex(WRF, '0, 5'h04, 8'h20);
      ex(WRF, '0, 5'h06, 8'h2a);
      ex(WRF, '0, 5'h05, 8'hc3);
      ex(SETB, '0, 5'h01, 8'h04);
      ex(SETB, '0, 5'h01, 8'h06);
      chk({flash_wr, flash_erase, stall, flash_addr, flash_wdata}, 24'h2c2ac3);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv & 8'h0a, 8'h00);
      ex(SETB, '0, 5'h01, 8'h01);
      chk({flash_rd, stall}, 2'b11);
      ex(RDF, '0, 5'h05, '0);
      chk(rdv, 8'hc3);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv[0], 1'b0);
      ex(WRF, '0, 5'h01, 8'h00);
      ex(SETB, '0, 5'h01, 8'h02);
      chk({flash_wr, stall}, 2'b00);
      ex(SETB, '0, 5'h01, 8'h04);
      ex(NOP, '0, '0, '0);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv[2], 1'b0);
      ex(SETB, '0, 5'h01, 8'h10);
      ex(NOP, '0, '0, '0);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv[4], 1'b0);
      ex(SETB, '0, 5'h01, 8'h10);
      ex(SETB, '0, 5'h01, 8'h14);
      ex(SETB, '0, 5'h01, 8'h16);
      chk({flash_erase, flash_wr}, 2'b10);
      ex(RDF, '0, 5'h01, '0);
      chk(rdv & 8'h12, 8'h00);
   endtask : t_flash
   initial begin
      {op_jump, op_call, op_return, file_rd, file_wr, file_bsf} = NOP;
      op_literal = 9'h000;
      file_addr = 5'h00;
      file_wdata = 8'h00;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_branch();
      t_indirect();
      t_flash();
      t_cut();
      print_verdict();
   end
endmodule : test_pcsfa_core
